// ---- design/drc_cfg.svh ----
// constants of the device reset control block
`ifndef DRC_CFG_SVH
`define DRC_CFG_SVH

// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define DRC_CLK_PERIOD_NS 20
`define DRC_OSC_PERIOD_NS 50
`define DRC_PERIPHERAL_CLOCK_PERIOD_NS 20

// ----------------------------------------------------------------
// glitch filter
// ----------------------------------------------------------------
`define DRC_FILT_MIN_NS 475
`define DRC_FILT_MAX_NS 2000
// one sample beyond the least time, since a short pulse may straddle an extra edge
`define DRC_FILT_CYC ((`DRC_FILT_MIN_NS + `DRC_CLK_PERIOD_NS - 1) / `DRC_CLK_PERIOD_NS + 1)
`define DRC_FILT_W 5

// ----------------------------------------------------------------
// hold and sequence times
// ----------------------------------------------------------------
`define DRC_POR_HOLD_OSC 2256
`define DRC_WARM_HOLD_PERIPHERAL_CLOCK 32
`define DRC_SEQ_OSC 3497
`define DRC_NS_TO_CYC(ns) (((ns) + `DRC_CLK_PERIOD_NS - 1) / `DRC_CLK_PERIOD_NS)
`define DRC_POR_HOLD_CYC `DRC_NS_TO_CYC(`DRC_POR_HOLD_OSC * `DRC_OSC_PERIOD_NS)
`define DRC_WARM_HOLD_CYC `DRC_NS_TO_CYC(`DRC_WARM_HOLD_PERIPHERAL_CLOCK * `DRC_PERIPHERAL_CLOCK_PERIOD_NS)
`define DRC_SEQ_CYC `DRC_NS_TO_CYC(`DRC_SEQ_OSC * `DRC_OSC_PERIOD_NS)
`define DRC_CNT_W 16

// ----------------------------------------------------------------
// status flag layout
// ----------------------------------------------------------------
`define DRC_FLAG_W 16
`define DRC_EXC_POR 15
`define DRC_EXC_WDG 13
`define DRC_EXC_STC 5
`define DRC_EXC_SW 4
`define DRC_EXC_EXT 3
`define DRC_GLB_OSC 0
`define DRC_GLB_SLIP0 8
`define DRC_GLB_SLIP1 9
`define DRC_EXC_RST 16'h8000
`define DRC_GLB_RST 16'h0000
`define DRC_RESET_VECTOR 32'h0000_0000

`endif

// ---- design/drc_pkg.sv ----
// types of the device reset control block
`include "drc_cfg.svh"
package drc_pkg;

  // sequencer phase
  typedef enum logic [1:0] {
    DRC_ST_POR,
    DRC_ST_HOLD,
    DRC_ST_RUN
  } drc_phase_t;

  // glitch filter state
  typedef struct packed {
    logic [`DRC_FILT_W-1:0] cnt;
    logic lvl;
  } drc_filt_t;

  // whole block state
  typedef struct packed {
    drc_phase_t phase;
    drc_filt_t por_filt;
    drc_filt_t pin_filt;
    logic [`DRC_CNT_W-1:0] hold_cnt;
    logic [`DRC_CNT_W-1:0] seq_cnt;
    logic pin_drive;
    logic cpu_reset_n;
    logic [`DRC_FLAG_W-1:0] exc_flags;
    logic [`DRC_FLAG_W-1:0] glb_flags;
  } drc_state_t;

endpackage

// ---- design/drc_top.sv ----
// device reset control: input filters, warm reset pin driver, cause flags
`timescale 1ns/1ps
`include "drc_cfg.svh"
module drc_top #(
  parameter int unsigned POR_HOLD_CYC = `DRC_POR_HOLD_CYC,
  parameter int unsigned SEQ_CYC = `DRC_SEQ_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // external supervisor
  input wire logic power_on_reset_in_n,
  // warm reset pin, open drain
  input wire logic warm_reset_pin_n_in,
  output logic warm_reset_pin_n_out,
  output logic warm_reset_pin_n_oe,
  // internal reset causes, one-cycle pulses
  input wire logic main_oscillator_fail,
  input wire logic pll_slip,
  input wire logic watchdog_reset,
  input wire logic debugger_reset,
  input wire logic cpu_self_test_controller_reset,
  input wire logic software_reset,
  // software clear, write one to clear
  input wire logic [`DRC_FLAG_W-1:0] exc_flags_clr,
  input wire logic [`DRC_FLAG_W-1:0] glb_flags_clr,
  // status
  output logic [`DRC_FLAG_W-1:0] exc_flags,
  output logic [`DRC_FLAG_W-1:0] glb_flags,
  // cpu side
  output logic cpu_reset_n,
  output logic [31:0] cpu_boot_addr,
  output logic device_reset_active
);
  import drc_pkg::*;

  // ----------------------------------------------------------------
  // overview
  // ----------------------------------------------------------------
  // all times are counted in clk_sys edges from the edge that takes a request
  // - each input filter needs a full window of equal samples before it takes a
  //   new level, so a short glitch never reaches the sequencing logic
  // - power-on: pin driven and cpu held while the supervisor input is low; on its
  //   filtered release the hold counter and the power-up sequence counter start
  // - warm cause: flag set and pin driven on the edge that takes it, released
  //   when the hold runs out; a further cause while holding only lengthens it
  // - an outside pull counts only as a filtered falling edge while we are not driving
  // - the cpu leaves reset once the pin is released and seen high again, so a
  //   board that keeps the pin low keeps the cpu in reset as well
  // - a clear strobe and a cause in one cycle leave the flag set, so software
  //   never loses an event that raced with its own clear
  // limitation: oscillator and peripheral clock periods are build-time constants,
  // so hold times become clk_sys edges by a conversion that always rounds up

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // a level is accepted only once stable for the whole filter window;
  // any bounce restarts the count, so short pulses never get through
  function automatic drc_filt_t drc_filter(input drc_filt_t cur, input logic raw);
    drc_filt_t nxt;
    nxt = cur;
    if (raw == cur.lvl) begin
      nxt.cnt = '0;
    end else if (cur.cnt == `DRC_FILT_W'(`DRC_FILT_CYC - 1)) begin
      nxt.lvl = raw;
      nxt.cnt = '0;
    end else begin
      nxt.cnt = cur.cnt + `DRC_FILT_W'(1);
    end
    return nxt;
  endfunction

  // extend a hold count, never shorten one already running
  function automatic logic [`DRC_CNT_W-1:0] drc_extend(input logic [`DRC_CNT_W-1:0] cur,
                                                     input logic [`DRC_CNT_W-1:0] req);
    return (req > cur) ? req : cur;
  endfunction

  // count down to zero and stay there, so a finished count never wraps
  function automatic logic [`DRC_CNT_W-1:0] drc_countdown(input logic [`DRC_CNT_W-1:0] cur);
    logic [`DRC_CNT_W-1:0] nxt;
    nxt = cur;
    if (cur != '0) begin
      nxt = cur - `DRC_CNT_W'(1);
    end
    return nxt;
  endfunction

  // hold and sequence lengths in clk_sys edges
  localparam logic [`DRC_CNT_W-1:0] POR_HOLD = `DRC_CNT_W'(POR_HOLD_CYC);
  localparam logic [`DRC_CNT_W-1:0] SEQ_LEN = `DRC_CNT_W'(SEQ_CYC);
  localparam logic [`DRC_CNT_W-1:0] WARM_HOLD = `DRC_CNT_W'(`DRC_WARM_HOLD_CYC);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // registered state and its next value
  drc_state_t state_reg;
  drc_state_t state_next;
  // filter outputs and decoded requests of this cycle
  drc_filt_t por_f;
  drc_filt_t pin_f;
  logic por_seen;
  logic ext_req;
  logic warm_req;
  logic [`DRC_FLAG_W-1:0] exc_set;
  logic [`DRC_FLAG_W-1:0] glb_set;

  // filtered inputs and cause decode
  always_comb begin
    por_f = drc_filter(state_reg.por_filt, power_on_reset_in_n);
    pin_f = drc_filter(state_reg.pin_filt, warm_reset_pin_n_in);
    por_seen = !por_f.lvl;
    // a filtered falling edge while we are not pulling the pin is someone else's request;
    // our own release is ignored because the filtered level only rises then
    ext_req = state_reg.pin_filt.lvl && !pin_f.lvl && !state_reg.pin_drive;
    // every cause but power-on leads to the same warm hold
    warm_req = main_oscillator_fail || pll_slip || watchdog_reset || debugger_reset ||
               cpu_self_test_controller_reset || software_reset || ext_req;
    // one flag per cause, but watchdog and debugger share bit 13; a pll slip marks two bits at once
    exc_set = '0;
    glb_set = '0;
    exc_set[`DRC_EXC_WDG] = watchdog_reset || debugger_reset;
    exc_set[`DRC_EXC_STC] = cpu_self_test_controller_reset;
    exc_set[`DRC_EXC_SW] = software_reset;
    exc_set[`DRC_EXC_EXT] = ext_req;
    glb_set[`DRC_GLB_OSC] = main_oscillator_fail;
    glb_set[`DRC_GLB_SLIP0] = pll_slip;
    glb_set[`DRC_GLB_SLIP1] = pll_slip;
  end

  // next state
  always_comb begin
    state_next = state_reg;
    // filters always advance, whatever the phase
    state_next.por_filt = por_f;
    state_next.pin_filt = pin_f;
    // both counters run down on their own and stop at zero
    state_next.hold_cnt = drc_countdown(state_reg.hold_cnt);
    state_next.seq_cnt = drc_countdown(state_reg.seq_cnt);
    // flags: hardware set wins over a clear in the same cycle
    state_next.exc_flags = (state_reg.exc_flags & ~exc_flags_clr) | exc_set;
    state_next.glb_flags = (state_reg.glb_flags & ~glb_flags_clr) | glb_set;
    unique case (state_reg.phase)
      DRC_ST_POR: begin
        // pin held low all through power-on reset
        if (!por_seen) begin
          state_next.phase = DRC_ST_HOLD;
          state_next.hold_cnt = POR_HOLD;
          state_next.seq_cnt = SEQ_LEN;
        end
      end
      DRC_ST_HOLD: begin
        // a new cause while holding may only lengthen the hold
        if (warm_req) begin
          state_next.hold_cnt = drc_extend(state_next.hold_cnt, WARM_HOLD);
        end
        if (state_reg.hold_cnt == '0 && state_reg.seq_cnt == '0) begin
          state_next.phase = DRC_ST_RUN;
        end
      end
      DRC_ST_RUN: begin
        // any cause from run starts a fresh warm hold
        if (warm_req) begin
          state_next.phase = DRC_ST_HOLD;
          state_next.hold_cnt = WARM_HOLD;
        end
      end
    endcase
    // power-on reset overrides everything and restarts the flags
    if (por_seen) begin
      state_next.phase = DRC_ST_POR;
      state_next.hold_cnt = '0;
      state_next.seq_cnt = '0;
      state_next.exc_flags = `DRC_EXC_RST;
      state_next.exc_flags[`DRC_EXC_POR] = 1'b1;
      state_next.glb_flags = `DRC_GLB_RST;
    end
    // drive the pin for any reset condition still pending
    state_next.pin_drive = (state_next.phase != DRC_ST_RUN) || (state_next.hold_cnt != '0);
    // cpu leaves reset only once the sequence is over and nobody holds the pin
    state_next.cpu_reset_n = (state_next.phase == DRC_ST_RUN) && pin_f.lvl;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // internal reset looks like a fresh power-up: pin low, filters at the active level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.phase <= DRC_ST_POR;
      state_reg.por_filt <= '0;
      state_reg.pin_filt <= '0;
      state_reg.hold_cnt <= '0;
      state_reg.seq_cnt <= '0;
      state_reg.pin_drive <= 1'b1;
      state_reg.cpu_reset_n <= 1'b0;
      state_reg.exc_flags <= `DRC_EXC_RST;
      state_reg.glb_flags <= `DRC_GLB_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // open drain: the output value is always low, only the enable moves
  assign warm_reset_pin_n_out = 1'b0;
  assign warm_reset_pin_n_oe = state_reg.pin_drive;
  // status and cpu side straight from the state register
  assign exc_flags = state_reg.exc_flags;
  assign glb_flags = state_reg.glb_flags;
  assign cpu_reset_n = state_reg.cpu_reset_n;
  // the first fetch always starts at the reset vector
  assign cpu_boot_addr = `DRC_RESET_VECTOR;
  assign device_reset_active = state_reg.pin_drive;

endmodule // drc_top

// ---- tb/drc_monitor.sv ----
// port checker of the device reset control block
`timescale 1ns/1ps
module drc_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // pin and causes
  input wire logic warm_reset_pin_n_out,
  input wire logic warm_reset_pin_n_oe,
  input wire logic software_reset,
  input wire logic watchdog_reset,
  input wire logic debugger_reset,
  input wire logic pll_slip,
  input wire logic main_oscillator_fail,
  input wire logic [15:0] exc_flags_clr,
  // status
  input wire logic [15:0] exc_flags,
  input wire logic [15:0] glb_flags,
  input wire logic cpu_reset_n,
  input wire logic [31:0] cpu_boot_addr,
  input wire logic device_reset_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // open drain: the value is always low, only the enable moves
  drive_low_a: assert property (warm_reset_pin_n_out == 1'b0) else $error("pin value not low");
  active_mirror_a: assert property (device_reset_active == warm_reset_pin_n_oe) else $error("active flag off");
  boot_zero_a: assert property (cpu_boot_addr == 32'h0000_0000) else $error("boot address not zero");
  cpu_held_a: assert property (cpu_reset_n |-> !warm_reset_pin_n_oe) else $error("cpu run while pin driven");
  // causes are judged from run phase only, where the pin is released
  sw_flag_a: assert property (software_reset && !warm_reset_pin_n_oe |=> exc_flags[4] && warm_reset_pin_n_oe)
    else $error("software cause not taken");
  warm_hold_a: assert property (software_reset && !warm_reset_pin_n_oe |=> ##32 warm_reset_pin_n_oe)
    else $error("warm hold too short");
  wdg_flag_a: assert property ((watchdog_reset || debugger_reset) && !warm_reset_pin_n_oe |=> exc_flags[13])
    else $error("watchdog flag not set");
  slip_flag_a: assert property (pll_slip && !warm_reset_pin_n_oe |=> glb_flags[9:8] == 2'b11)
    else $error("slip flags not set");
  osc_flag_a: assert property (main_oscillator_fail && !warm_reset_pin_n_oe |=> glb_flags[0])
    else $error("oscillator flag not set");
  flag_keep_a: assert property ($fell(exc_flags[4]) |-> $past(exc_flags_clr[4]) || exc_flags[15])
    else $error("flag lost without clear");
endmodule // drc_monitor

// ---- tb/drc_board.sv ----
// board model: pull-up on the warm reset pin and an external reset switch
`timescale 1ns/1ps
module drc_board (
  // device side
  input wire logic pin_oe,
  input wire logic pin_out,
  // external switch, high pulls the pin low
  input wire logic ext_pull,
  // resolved level
  output logic pin_level
);
  // pull-up wins only when no party pulls, so a released pin never keeps a stale low
  assign pin_level = !(pin_oe && !pin_out) && !ext_pull;
endmodule // drc_board

// ---- tb/testbench.sv ----
// self-checking bench of the device reset control block
`timescale 1ns/1ps
`include "drc_cfg.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic por_n = 1'b1;
  logic ext_pull = 1'b0;
  logic [5:0] cause = 6'h00;
  logic [15:0] exc_clr = 16'h0000;
  logic [15:0] glb_clr = 16'h0000;
  logic pin_n, pin_out, pin_oe, cpu_reset_n, active;
  logic [15:0] exc_flags, glb_flags;
  logic [31:0] boot_addr;
  int n_errors = 0;
  int checks = 0;
  int cnt;
  // short hold and sequence counts keep the power-on path quick
  drc_top #(.POR_HOLD_CYC(40), .SEQ_CYC(60)) DUT (.clk_sys, .rst_b, .power_on_reset_in_n(por_n),
    .warm_reset_pin_n_in(pin_n), .warm_reset_pin_n_out(pin_out), .warm_reset_pin_n_oe(pin_oe),
    .main_oscillator_fail(cause[0]), .pll_slip(cause[1]), .watchdog_reset(cause[2]), .debugger_reset(cause[3]),
    .cpu_self_test_controller_reset(cause[4]), .software_reset(cause[5]), .exc_flags_clr(exc_clr),
    .glb_flags_clr(glb_clr), .exc_flags, .glb_flags, .cpu_reset_n, .cpu_boot_addr(boot_addr),
    .device_reset_active(active));
  drc_board board (.pin_oe, .pin_out, .ext_pull, .pin_level(pin_n));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // count cycles of pin drive, bounded so a stuck pin cannot hang the run
  task automatic hold_len();
    cnt = 0;
    while (pin_oe === 1'b1 && cnt < 400) begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask
  task automatic wait_cpu();
    for (int i = 0; i < 400 && cpu_reset_n !== 1'b1; i++) @(negedge clk_sys);
    chk("cpu run", 32'h1, cpu_reset_n);
  endtask
  task automatic clr(input logic [31:0] m);
    @(posedge clk_sys) {glb_clr, exc_clr} <= m;
    @(posedge clk_sys) {glb_clr, exc_clr} <= 32'h0;
    @(negedge clk_sys) chk("cleared", 32'h0, {glb_flags, exc_flags});
  endtask
  // low pulse of len samples on the pin (pin=1) or on the supervisor input
  task automatic pulse(input bit pin, input int len);
    @(posedge clk_sys) if (pin) ext_pull <= 1'b1; else por_n <= 1'b0;
    repeat (len) @(posedge clk_sys);
    ext_pull <= 1'b0;
    por_n <= 1'b1;
    repeat (30) @(negedge clk_sys);
  endtask
  function automatic logic [31:0] mask_of(input int i);
    case (i)
      0: return 32'h0001_0000;
      1: return 32'h0300_0000;
      2, 3: return 32'h0000_2000;
      4: return 32'h0000_0020;
      default: return 32'h0000_0010;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic por_release();
    chk("reset flags", 32'h0000_8000, {glb_flags, exc_flags});
    @(posedge clk_sys) rst_b <= 1'b1;
    hold_len();
    chk("por hold", 32'h1, cnt >= 65);
    wait_cpu();
    chk("boot", 32'h0, boot_addr);
    clr(32'h0000_8000);
  endtask
  task automatic warm_causes();
    logic [31:0] m;
    for (int i = 0; i < 6; i++) begin
      m = mask_of(i);
      @(posedge clk_sys) cause <= 6'h01 << i;
      @(posedge clk_sys) cause <= 6'h00;
      @(negedge clk_sys) chk("cause flag", m, {glb_flags, exc_flags});
      hold_len();
      chk("warm hold", `DRC_WARM_HOLD_CYC + 1, cnt);
      wait_cpu();
      chk("kept flag", m, {glb_flags, exc_flags});
      clr(m);
    end
  endtask
  task automatic pin_glitch();
    pulse(1'b1, 24);
    chk("short pin", 32'h0, {glb_flags, exc_flags});
    chk("short pin drive", 32'h0, pin_oe);
    pulse(1'b1, 25);
    chk("ext flag", 32'h0000_0008, {glb_flags, exc_flags});
    chk("ext drive", 32'h1, pin_oe);
    wait_cpu();
    clr(32'h0000_0008);
  endtask
  task automatic por_glitch();
    pulse(1'b0, 24);
    chk("short por", 32'h0, {glb_flags, exc_flags});
    chk("short por drive", 32'h0, pin_oe);
    pulse(1'b0, 25);
    chk("por flags", 32'h0000_8000, {glb_flags, exc_flags});
    chk("por drive", 32'h1, pin_oe);
    wait_cpu();
  endtask
  task automatic results();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    por_release();
    warm_causes();
    pin_glitch();
    por_glitch();
    results();
  end
  // watchdog: the whole sequence needs under a thousand cycles
  initial begin
    #(20 * 20000);
    n_errors++;
    results();
  end
endmodule // testbench
bind drc_top drc_monitor mon (.clk_sys, .rst_b, .warm_reset_pin_n_out, .warm_reset_pin_n_oe, .software_reset,
  .watchdog_reset, .debugger_reset, .pll_slip, .main_oscillator_fail, .exc_flags_clr, .exc_flags, .glb_flags,
  .cpu_reset_n, .cpu_boot_addr, .device_reset_active);
